/* core/ipoc_consts.svh */
// Offsets, field positions, reset values and timing counts of the
// input, power and output control register group.
// Assumes a 32-bit AHB-Lite register port and a 10 MHz system clock.
`ifndef IPOC_CONSTS_SVH
`define IPOC_CONSTS_SVH

// Register indices; byte address is four times the index
`define IDX_INPUT_POWER 8'h1E
`define IDX_OUTPUT_FORMAT 8'h1F
`define IDX_CLOCK_TRISTATE 8'h20
`define IDX_SYNC_ACTIVITY 8'h24
`define IDX_BLOCK_STATE 8'h30

// Input and power control fields
`define POS_CH_OVERRIDE 7
`define POS_CH_SELECT 6
`define POS_BW_HIGH 5
`define POS_PD_AUTO 4
`define POS_PD_BIT 3
`define POS_PD_PIN_POL 2
`define POS_PD_FAST 1
`define POS_PD_GSYNC_HIZ 0

// Output format fields
`define POS_MODE_HI 7
`define POS_MODE_LO 5
`define POS_PRIM_EN 4
`define POS_SEC_EN 3
`define POS_DRIVE_HI 2
`define POS_DRIVE_LO 1
`define POS_CLK_INV 0

// Output clock and tristate fields
`define POS_CLKSEL_HI 7
`define POS_CLKSEL_LO 6
`define POS_ALL_HIZ 5
`define POS_GSYNC_HIZ 4
`define POS_FIELD_POL 3

// Sync activity status fields
`define POS_ACT_LINE0 7
`define POS_ACT_LINE1 6
`define POS_ACT_GREEN0 3
`define POS_ACT_GREEN1 2

// Reset values
`define RST_INPUT_POWER 8'h24
`define RST_OUTPUT_FORMAT 8'h94
`define RST_CLOCK_TRISTATE 8'h08

// Output mode codes
`define MODE_RGB444 3'h4
`define MODE_YCC422 3'h5
`define MODE_DDR444 3'h6

// Output clock choices
`define CLKSEL_PIXEL 2'h0
`define CLKSEL_SHIFT90 2'h1
`define CLKSEL_DOUBLE 2'h2
`define CLKSEL_FIXED 2'h3

// Timing
`define CLK_HZ 10000000
`define FIXED_CLK_HZ 40000000
`define ACT_WINDOW_US 100
`define ACT_WINDOW_CYCLES (`ACT_WINDOW_US * (`CLK_HZ / 1000000))

`endif

/* core/ipoc_pkg.sv */
// Types shared by the control register group and its bench.
// Assumes nothing beyond a SystemVerilog elaborator.
package ipoc_pkg;

  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
  } pixel_s;

  typedef struct packed {
    logic [1:0] line_sync;
    logic [1:0] green_sync;
    logic [1:0] vert_sync;
    logic power_down_pin;
    logic pixel_clock;
  } sync_pins_s;

  typedef struct packed {
    logic red_oe;
    logic green_oe;
    logic blue_oe;
    logic clock_oe;
    logic vsync_oe;
    logic field_oe;
    logic gsync_oe;
  } out_enables_s;

endpackage

/* core/input_power_output_control.sv */
// Input selection, power-down and pixel output control register group.
// Assumes an AHB-Lite master on clk, asynchronous sync and data pins,
// and a pixel clock that is far slower than clk.
`timescale 1ns/1ps
`include "ipoc_consts.svh"

// Function
// - Override clear: device picks channel itself
// - Override set: channel bit selects input
// - Bandwidth bit: 0 low, 1 high
// - Auto power-down follows sync activity flags
// - Manual: register bit or active pin
// - Pin polarity bit: 0 low, 1 high
// - Fast switching: only tri-state outputs
// - Green-sync output optionally tri-stated in power-down
// - Mode field selects RGB, YCbCr, DDR
// - 4:2:2 drives sixteen primary pins
// - DDR mode changes on both edges
// - Primary enable bit drives or tri-states
// - Blue carries secondary in 4:2:2/DDR
// - Secondary is DDR YCbCr, own enable
// - Drive field selects four strengths
// - Clock invert bit inverts output clock
// - Clock select: pixel, 90deg, double, fixed
// - Global tri-state except green-sync output
// - Separate green-sync tri-state bit
// - Field polarity bit maps odd/even
// - Activity flag only for toggling sync
module input_power_output_control #(
  parameter int ACT_WINDOW = `ACT_WINDOW_CYCLES
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire ipoc_pkg::sync_pins_s pins,
  input wire ipoc_pkg::pixel_s ch0_data,
  input wire ipoc_pkg::pixel_s ch1_data,
  input wire logic field_odd,
  output ipoc_pkg::pixel_s pixel_out,
  output ipoc_pkg::out_enables_s out_oe,
  output logic out_clock,
  output logic green_sync_output,
  output logic vertical_sync_output,
  output logic field_output,
  output logic [1:0] drive_strength,
  output logic high_bandwidth,
  output logic device_powered_down,
  output logic active_channel
);

  localparam int FIX_DIV = `CLK_HZ / (2 * `FIXED_CLK_HZ);
  localparam int FIX_HALF = (FIX_DIV < 1) ? 1 : FIX_DIV;

  if (ACT_WINDOW < 2) begin : g_bad_window
    $error("ACT_WINDOW must be at least 2 cycles");
  end

  // Two-flop synchronisers for every pin and data input
  // Data rides in the same word as the pixel clock, so both cross together
  localparam int SW = $bits(ipoc_pkg::sync_pins_s) + 49;
  logic [SW-1:0] meta_r;
  logic [SW-1:0] sync_r;
  always_ff @(posedge clk) begin
    if (srst) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= {pins, ch0_data, ch1_data, field_odd};
      sync_r <= meta_r;
    end
  end

  ipoc_pkg::sync_pins_s pins_s;
  ipoc_pkg::pixel_s ch0_s;
  ipoc_pkg::pixel_s ch1_s;
  logic field_odd_s;
  assign {pins_s, ch0_s, ch1_s, field_odd_s} = sync_r;

  // Registers
  logic [7:0] inpwr_r;
  logic [7:0] outfmt_r;
  logic [7:0] clktri_r;

  // AHB-Lite slave, zero wait states
  // Read data is loaded in the address phase, so no wait state is needed
  logic wr_pend_r;
  logic [7:0] wr_idx_r;
  logic addr_ok;
  logic [7:0] addr_idx;
  logic [7:0] act_status;
  logic [7:0] state_status;
  logic [7:0] rd_val;
  assign addr_idx = haddr[9:2];
  assign addr_ok = (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'h0);
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  // hsize is not decoded; every access is taken as a whole word

  always_comb begin
    rd_val = 8'h00;
    if (addr_ok) begin
      case (addr_idx)
        `IDX_INPUT_POWER: rd_val = inpwr_r;
        `IDX_OUTPUT_FORMAT: rd_val = outfmt_r;
        `IDX_CLOCK_TRISTATE: rd_val = clktri_r;
        `IDX_SYNC_ACTIVITY: rd_val = act_status;
        `IDX_BLOCK_STATE: rd_val = state_status;
        default: rd_val = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wr_pend_r <= 1'b0;
      wr_idx_r <= 8'h00;
      hrdata <= 32'h00000000;
    end else if (hready) begin
      wr_pend_r <= hsel && htrans[1] && hwrite && addr_ok;
      wr_idx_r <= addr_idx;
      if (hsel && htrans[1] && !hwrite) begin
        hrdata <= {24'h000000, rd_val};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      inpwr_r <= `RST_INPUT_POWER;
      outfmt_r <= `RST_OUTPUT_FORMAT;
      clktri_r <= `RST_CLOCK_TRISTATE;
    end else if (wr_pend_r) begin
      case (wr_idx_r)
        `IDX_INPUT_POWER: inpwr_r <= hwdata[7:0];
        `IDX_OUTPUT_FORMAT: begin
          outfmt_r[4:0] <= hwdata[4:0];
          if (hwdata[7:5] == `MODE_RGB444 || hwdata[7:5] == `MODE_YCC422 ||
              hwdata[7:5] == `MODE_DDR444) begin
            outfmt_r[7:5] <= hwdata[7:5];
          end
        end
        `IDX_CLOCK_TRISTATE: clktri_r <= hwdata[7:0];
        // Status words are read only, so writes to them drop here
        default: ;
      endcase
    end
  end

  // Sync activity: a flag stays set for one window after any edge
  // A level held high or low never reloads the window, so it reads idle
  logic [3:0] act_in;
  logic [3:0] act_prev_r;
  logic [3:0] act_flag;
  assign act_in = {pins_s.line_sync, pins_s.green_sync};
  always_ff @(posedge clk) begin
    if (srst) begin
      act_prev_r <= 4'h0;
    end else begin
      act_prev_r <= act_in;
    end
  end

  for (genvar i = 0; i < 4; i++) begin : g_act
    logic [$clog2(ACT_WINDOW+1)-1:0] cnt_r;
    always_ff @(posedge clk) begin
      if (srst) begin
        cnt_r <= '0;
      end else if (act_in[i] != act_prev_r[i]) begin
        cnt_r <= ($clog2(ACT_WINDOW+1))'(ACT_WINDOW);
      end else if (cnt_r != '0) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
    assign act_flag[i] = (cnt_r != '0);
  end

  always_comb begin
    act_status = 8'h00;
    act_status[`POS_ACT_LINE0] = act_flag[2];
    act_status[`POS_ACT_LINE1] = act_flag[3];
    act_status[`POS_ACT_GREEN0] = act_flag[0];
    act_status[`POS_ACT_GREEN1] = act_flag[1];
  end

  // Channel choice
  // With override clear, channel 0 wins when both inputs carry sync
  logic ch0_active;
  logic ch1_active;
  logic chan;
  assign ch0_active = act_flag[2] | act_flag[0];
  assign ch1_active = act_flag[3] | act_flag[1];
  always_comb begin
    if (inpwr_r[`POS_CH_OVERRIDE]) begin
      chan = inpwr_r[`POS_CH_SELECT];
    end else begin
      chan = !ch0_active && ch1_active;
    end
  end

  // Power-down decision
  // Pin polarity matters only in manual mode; auto ignores the pin
  logic pin_active;
  logic pd_req;
  logic pd_full;
  assign pin_active = pins_s.power_down_pin ~^ inpwr_r[`POS_PD_PIN_POL];
  always_comb begin
    if (inpwr_r[`POS_PD_AUTO]) begin
      pd_req = !(|act_flag);
    end else begin
      pd_req = inpwr_r[`POS_PD_BIT] | pin_active;
    end
  end
  assign pd_full = pd_req && !inpwr_r[`POS_PD_FAST];

  // Pixel clock edges and half-period measure
  logic pclk_prev_r;
  logic p_rise;
  logic p_fall;
  logic [15:0] since_edge_r;
  logic [15:0] half_r;
  assign p_rise = pins_s.pixel_clock && !pclk_prev_r;
  assign p_fall = !pins_s.pixel_clock && pclk_prev_r;
  always_ff @(posedge clk) begin
    if (srst) begin
      pclk_prev_r <= 1'b0;
      since_edge_r <= 16'h0000;
      half_r <= 16'h0000;
    end else begin
      pclk_prev_r <= pins_s.pixel_clock;
      if (p_rise || p_fall) begin
        since_edge_r <= 16'h0000;
        half_r <= since_edge_r;
      end else if (since_edge_r != 16'hFFFF) begin
        since_edge_r <= since_edge_r + 16'h0001;
      end
    end
  end

  // Derived clocks; the 90 degree and double clocks are rebuilt from
  // the measured half period, so they lag by one clk of resolution
  logic mid_hit;
  logic shift_r;
  logic double_r;
  logic fixed_r;
  logic [$clog2(FIX_HALF+1)-1:0] fix_cnt_r;
  assign mid_hit = (since_edge_r == {1'b0, half_r[15:1]}) && !(p_rise || p_fall);
  always_ff @(posedge clk) begin
    if (srst) begin
      shift_r <= 1'b0;
      double_r <= 1'b0;
    end else begin
      if (mid_hit) begin
        shift_r <= pclk_prev_r;
      end
      if (p_rise || p_fall || mid_hit) begin
        double_r <= !double_r;
      end
    end
  end

  // Fixed clock is bounded by clk; at 10 MHz it cannot reach 40 MHz
  always_ff @(posedge clk) begin
    if (srst) begin
      fix_cnt_r <= '0;
      fixed_r <= 1'b0;
    end else if (fix_cnt_r == ($clog2(FIX_HALF+1))'(FIX_HALF - 1)) begin
      fix_cnt_r <= '0;
      fixed_r <= !fixed_r;
    end else begin
      fix_cnt_r <= fix_cnt_r + 1'b1;
    end
  end

  logic clk_pick;
  always_comb begin
    case (clktri_r[`POS_CLKSEL_HI:`POS_CLKSEL_LO])
      `CLKSEL_PIXEL: clk_pick = pclk_prev_r;
      `CLKSEL_SHIFT90: clk_pick = shift_r;
      `CLKSEL_DOUBLE: clk_pick = double_r;
      default: clk_pick = fixed_r;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      out_clock <= 1'b0;
    end else begin
      out_clock <= clk_pick ^ outfmt_r[`POS_CLK_INV];
    end
  end

  // Pixel formatter; frozen in full power-down
  ipoc_pkg::pixel_s sel_px;
  logic [2:0] mode;
  assign sel_px = chan ? ch1_s : ch0_s;
  assign mode = outfmt_r[`POS_MODE_HI:`POS_MODE_LO];

  always_ff @(posedge clk) begin
    if (srst) begin
      pixel_out <= '0;
    end else if (!pd_full) begin
      case (mode)
        `MODE_DDR444: begin
          if (p_rise || p_fall) begin
            pixel_out <= sel_px;
          end
        end
        `MODE_YCC422: begin
          if (p_rise) begin
            pixel_out.red <= sel_px.red;
            pixel_out.green <= sel_px.green;
            pixel_out.blue <= sel_px.blue;
          end else if (p_fall) begin
            pixel_out.blue <= sel_px.green;
          end
        end
        default: begin
          if (p_rise) begin
            pixel_out <= sel_px;
          end
        end
      endcase
    end
  end

  // Side outputs
  always_ff @(posedge clk) begin
    if (srst) begin
      green_sync_output <= 1'b0;
      vertical_sync_output <= 1'b0;
      field_output <= 1'b0;
    end else begin
      green_sync_output <= pins_s.green_sync[chan];
      vertical_sync_output <= pins_s.vert_sync[chan];
      field_output <= field_odd_s ^ clktri_r[`POS_FIELD_POL];
    end
  end

  // Output enables
  // Any power-down request lets go of all outputs but green sync, which has its own bit, fast switching or not
  logic hiz_all;
  logic split_mode;
  assign hiz_all = clktri_r[`POS_ALL_HIZ] || pd_req;
  assign split_mode = (mode == `MODE_YCC422) || (mode == `MODE_DDR444);
  always_comb begin
    out_oe.red_oe = outfmt_r[`POS_PRIM_EN] && !hiz_all;
    out_oe.green_oe = outfmt_r[`POS_PRIM_EN] && !hiz_all;
    if (split_mode) begin
      out_oe.blue_oe = outfmt_r[`POS_SEC_EN] && !hiz_all;
    end else begin
      out_oe.blue_oe = outfmt_r[`POS_PRIM_EN] && !hiz_all;
    end
    out_oe.clock_oe = !hiz_all;
    out_oe.vsync_oe = !hiz_all;
    out_oe.field_oe = !hiz_all;
    out_oe.gsync_oe = !clktri_r[`POS_GSYNC_HIZ] &&
                      !(pd_req && inpwr_r[`POS_PD_GSYNC_HIZ]);
  end

  assign drive_strength = outfmt_r[`POS_DRIVE_HI:`POS_DRIVE_LO];
  assign high_bandwidth = inpwr_r[`POS_BW_HIGH];
  assign device_powered_down = pd_full;
  assign active_channel = chan;
  assign state_status = {5'h00, hiz_all, chan, pd_full};

endmodule

/* bench/ipoc_props.sv */
// Port checker; shadows the three control registers from bus writes.
// Assumes one AHB-Lite slave whose hready is its own hreadyout.
`timescale 1ns/1ps
`include "ipoc_consts.svh"
module ipoc_props #(
  parameter int ACT_WINDOW = 20
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire ipoc_pkg::out_enables_s out_oe,
  input wire logic out_clock,
  input wire logic [1:0] drive_strength,
  input wire logic high_bandwidth,
  input wire logic device_powered_down,
  input wire logic active_channel
);
  logic [7:0] ip_r, of_r, ct_r, ix_r;
  logic wr_r;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  always_ff @(posedge clk) begin
    if (srst) begin
      wr_r <= 1'b0;
    end else if (hready) begin
      wr_r <= hsel && htrans[1] && hwrite;
      ix_r <= haddr[9:2];
    end
  end
  // Shadow lands at the same edge as the design register
  always_ff @(posedge clk) begin
    if (srst) begin
      ip_r <= `RST_INPUT_POWER;
      of_r <= `RST_OUTPUT_FORMAT;
      ct_r <= `RST_CLOCK_TRISTATE;
    end else if (wr_r && hready) begin
      if (ix_r == `IDX_INPUT_POWER) ip_r <= hwdata[7:0];
      if (ix_r == `IDX_CLOCK_TRISTATE) ct_r <= hwdata[7:0];
      if (ix_r == `IDX_OUTPUT_FORMAT) begin
        of_r[4:0] <= hwdata[4:0];
        if (hwdata[7:5] inside {`MODE_RGB444, `MODE_YCC422, `MODE_DDR444})
          of_r[7:5] <= hwdata[7:5];
      end
    end
  end
  property p_chan; ip_r[7] |-> active_channel == ip_r[6]; endproperty
  property p_bw; high_bandwidth == ip_r[5]; endproperty
  property p_manual; !ip_r[4] && ip_r[3] && !ip_r[1] |-> device_powered_down; endproperty
  property p_fast; ip_r[1] |-> !device_powered_down; endproperty
  property p_pdoe; device_powered_down |-> out_oe[6:1] == 6'h00; endproperty
  property p_prim; !of_r[4] |-> !out_oe.red_oe && !out_oe.green_oe; endproperty
  property p_sec; of_r[7:5] != `MODE_RGB444 && !of_r[3] |-> !out_oe.blue_oe; endproperty
  property p_drive; drive_strength == of_r[2:1]; endproperty
  property p_allhiz; ct_r[5] |-> out_oe[6:1] == 6'h00; endproperty
  property p_gsync; ct_r[4] |-> !out_oe.gsync_oe; endproperty
  property p_fixclk; (ct_r[7:6] == 2'h3) [*3] |-> out_clock != $past(out_clock); endproperty
  a_chan: assert property (p_chan) else $error("channel not as chosen");
  a_bw: assert property (p_bw) else $error("bandwidth wrong");
  a_manual: assert property (p_manual) else $error("power-down bit ignored");
  a_fast: assert property (p_fast) else $error("fast switch powered down");
  a_pdoe: assert property (p_pdoe) else $error("outputs driven in power-down");
  a_prim: assert property (p_prim) else $error("primary driven while off");
  a_sec: assert property (p_sec) else $error("secondary driven while off");
  a_drive: assert property (p_drive) else $error("drive strength wrong");
  a_allhiz: assert property (p_allhiz) else $error("output driven in high impedance");
  a_gsync: assert property (p_gsync) else $error("green sync driven");
  a_fixclk: assert property (p_fixclk) else $error("fixed clock stalled");
  c_pd: cover property (device_powered_down);
  c_hiz: cover property (ct_r[5]);
  c_ch1: cover property (active_channel);
endmodule
bind input_power_output_control ipoc_props #(.ACT_WINDOW(ACT_WINDOW)) props_u (.clk, .srst,
  .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .out_oe, .out_clock, .drive_strength,
  .high_bandwidth, .device_powered_down, .active_channel);

/* bench/video_source.sv */
// Source model: pixel clock, channel data and a line sync.
// Assumes the bench frames traffic with run; clock idles low outside.
`timescale 1ns/1ps
module video_source (
  input wire logic run,
  output logic pclk,
  output logic line_sync,
  output ipoc_pkg::pixel_s ch0,
  output ipoc_pkg::pixel_s ch1
);
  logic [7:0] cnt_r = 8'h00;
  initial begin
    pclk = 1'b0;
    ch0 = '0;
    ch1 = '0;
    #137;
    forever begin
      #400;
      pclk = run ? ~pclk : 1'b0;
    end
  end
  assign line_sync = pclk;
  // Data moves on the fall, far from the sampled rise
  always @(negedge pclk) begin
    cnt_r <= cnt_r + 8'h01;
    ch0 <= {3{cnt_r}};
    ch1 <= ~{3{cnt_r}};
  end
endmodule

/* bench/test_input_power_output_control.sv */
// Bench of the control group: bus tasks, source model, port checks.
// Assumes design, package and header are compiled first.
`timescale 1ns/1ps
`include "ipoc_consts.svh"
module test_input_power_output_control;
  localparam logic [7:0] IP = `IDX_INPUT_POWER;
  localparam logic [7:0] OF = `IDX_OUTPUT_FORMAT;
  localparam logic [7:0] CT = `IDX_CLOCK_TRISTATE;
  logic clk = 0, srst = 1, hsel = 0, hwrite = 0, pd_pin = 0, field_odd = 0, run = 0, vs = 0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
  logic hreadyout, hresp, out_clock, fo, bw, pd, ach, pclk, ls, a, vso;
  logic [1:0] drv;
  logic [2:0] mw[5] = '{3'h5, 3'h7, 3'h6, 3'h0, 3'h4};
  logic [2:0] me[5] = '{3'h5, 3'h5, 3'h6, 3'h6, 3'h4};
  ipoc_pkg::pixel_s ch0, ch1, pix, exp_pix;
  ipoc_pkg::out_enables_s oe;
  ipoc_pkg::sync_pins_s pins;
  int failures = 0, checks_done = 0, cyc = 0;
  assign pins = {1'b0, ls, 2'h0, vs, 1'b0, pd_pin, pclk};
  always #50 clk = ~clk;
  input_power_output_control #(.ACT_WINDOW(20)) dut_u (.clk, .srst, .hsel, .haddr, .htrans,
    .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .pins,
    .ch0_data(ch0), .ch1_data(ch1), .field_odd, .pixel_out(pix), .out_oe(oe), .out_clock,
    .green_sync_output(), .vertical_sync_output(vso), .field_output(fo), .drive_strength(drv),
    .high_bandwidth(bw), .device_powered_down(pd), .active_channel(ach));
  video_source src_u (.run, .pclk, .line_sync(ls), .ch0, .ch1);
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] ix, input logic [7:0] v);
    haddr <= {22'h0, ix, 2'h0};
    htrans <= 2'h2;
    hwrite <= w;
    hsel <= 1'b1;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, v};
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] ix, input logic [7:0] v);
    xfer(1'b1, ix, v);
    @(posedge clk);
  endtask
  task automatic rchk(input logic [7:0] ix, input logic [7:0] e);
    xfer(1'b0, ix, 8'h00);
    chk("register", {24'h0, e}, rd);
  endtask
  task automatic end_sim;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Whole run needs about 270 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      end_sim();
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    rchk(IP, `RST_INPUT_POWER);
    rchk(OF, `RST_OUTPUT_FORMAT);
    rchk(CT, `RST_CLOCK_TRISTATE);
    rchk(8'h10, 8'h00);
    chk("hresp", 0, hresp);
    chk("high_bandwidth", 1, bw);
    $display("test reset done");
    foreach (mw[i]) begin
      wr(OF, {mw[i], 5'h14});
      rchk(OF, {me[i], 5'h14});
    end
    for (int d = 0; d < 4; d++) begin
      wr(OF, {3'h4, 2'h2, d[1:0], 1'b0});
      chk("drive_strength", d, drv);
    end
    wr(OF, 8'hB0);
    chk("blue_oe", 0, oe.blue_oe);
    chk("red_oe", 1, oe.red_oe);
    chk("green_oe", 1, oe.green_oe);
    wr(OF, 8'hB8);
    chk("blue_oe", 1, oe.blue_oe);
    wr(OF, 8'h88);
    chk("red_oe", 0, oe.red_oe);
    wr(OF, 8'h94);
    $display("test output format done");
    wr(IP, 8'h28);
    chk("powered_down", 1, pd);
    chk("gsync_oe", 1, oe.gsync_oe);
    wr(IP, 8'h29);
    chk("gsync_oe", 0, oe.gsync_oe);
    wr(IP, 8'h2A);
    chk("powered_down", 0, pd);
    chk("red_oe", 0, oe.red_oe);
    for (int k = 0; k < 4; k++) begin
      wr(IP, k[1] ? 8'h20 : 8'h24);
      pd_pin <= !k[0];
      repeat (4) @(posedge clk);
      chk("powered_down", k[1] ^ !k[0], pd);
    end
    pd_pin <= 1'b0;
    wr(IP, 8'h24);
    $display("test power-down done");
    wr(CT, 8'h28);
    rchk(CT, 8'h28);
    chk("out_oe", 7'h01, oe);
    wr(CT, 8'h18);
    chk("out_oe", 7'h7E, oe);
    wr(CT, 8'hC8);
    repeat (3) @(posedge clk);
    a = out_clock;
    @(posedge clk);
    chk("out_clock", !a, out_clock);
    wr(CT, 8'h08);
    wr(OF, 8'h95);
    repeat (6) @(posedge clk);
    chk("out_clock", 1, out_clock);
    wr(OF, 8'h94);
    field_odd <= 1'b1;
    repeat (6) @(posedge clk);
    chk("field_output", 0, fo);
    wr(CT, 8'h00);
    repeat (6) @(posedge clk);
    chk("field_output", 1, fo);
    wr(CT, 8'h08);
    $display("test output clock done");
    wr(IP, 8'hE4);
    run <= 1'b1;
    repeat (2) begin
      @(posedge pclk);
      exp_pix = ch1;
      repeat (6) @(posedge clk);
      chk("pixel_out", exp_pix, pix);
    end
    chk("active_channel", 1, ach);
    vs <= 1'b1;
    repeat (4) @(posedge clk);
    chk("vertical_sync_output", 1, vso);
    wr(OF, 8'hD4);
    @(negedge pclk);
    repeat (4) @(posedge clk);
    chk("pixel_out", ch1, pix);
    wr(OF, 8'h94);
    wr(IP, 8'h34);
    chk("active_channel", 0, ach);
    chk("powered_down", 0, pd);
    rchk(`IDX_SYNC_ACTIVITY, 8'h80);
    chk("vertical_sync_output", 0, vso);
    run <= 1'b0;
    repeat (60) @(posedge clk);
    chk("powered_down", 1, pd);
    rchk(`IDX_SYNC_ACTIVITY, 8'h00);
    $display("test link done");
    end_sim();
  end
endmodule
